/* hw/rifd_pkg.sv */
// Package with the constants and types of the remote input function dispatcher.
package rifd_pkg;
	localparam int NUM_INPUTS = 4;
	localparam int FUNC_W = 6;
	localparam logic [5:0] FUNC_MAX = 6'h24;
	localparam logic [5:0] FN_NONE = 6'h00;
	localparam logic [5:0] FN_TARE = 6'h01;
	localparam logic [5:0] FN_TARE_RESET = 6'h02;
	localparam logic [5:0] FN_PEAK = 6'h03;
	localparam logic [5:0] FN_VALLEY = 6'h04;
	localparam logic [5:0] FN_PV_CLEAR = 6'h05;
	localparam logic [5:0] FN_PV_CYCLE = 6'h06;
	localparam logic [5:0] FN_COMBINE = 6'h07;
	localparam logic [5:0] FN_FREEZE_ALT = 6'h08;
	localparam logic [5:0] FN_FREEZE = 6'h09;
	localparam logic [5:0] FN_SHOW_RAW = 6'h0a;
	localparam logic [5:0] FN_SHOW_GROSS = 6'h0b;
	localparam logic [5:0] FN_SHOW_TARE = 6'h0c;
	localparam logic [5:0] FN_ANA_TOTAL = 6'h0d;
	localparam logic [5:0] FN_ANA_ZERO = 6'h0e;
	localparam logic [5:0] FN_ANA_PEAK = 6'h0f;
	localparam logic [5:0] FN_ANA_VALLEY = 6'h10;
	localparam logic [5:0] FN_PRINT_NET = 6'h11;
	localparam logic [5:0] FN_PRINT_GROSS = 6'h12;
	localparam logic [5:0] FN_PRINT_TARE = 6'h13;
	localparam logic [5:0] FN_PRINT_SP1 = 6'h14;
	localparam logic [5:0] FN_PRINT_SP4 = 6'h17;
	localparam logic [5:0] FN_VIRT_SP = 6'h18;
	localparam logic [5:0] FN_LATCH_REL = 6'h19;
	localparam logic [5:0] FN_SER_RAW = 6'h1a;
	localparam logic [5:0] FN_BCD_RAW = 6'h1b;
	localparam logic [5:0] FN_SEND_ASCII = 6'h1c;
	// Factory assignment used while all four selectors read zero.
	localparam logic [5:0] DEF_FUNC0 = 6'h07;
	localparam logic [5:0] DEF_FUNC1 = 6'h09;
	localparam logic [5:0] DEF_FUNC2 = 6'h01;
	localparam logic [5:0] DEF_FUNC3 = 6'h06;
	// Register map, word addresses as byte offsets.
	localparam logic [7:0] REG_FUNC_SEL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CONFIG = 8'h08;
	localparam logic [31:0] FUNC_SEL_RESET = 32'h0000_0000;
	// Timing.
	localparam int CLK_HZ = 100_000_000;
	localparam int DEBOUNCE_US = 20;
	localparam int DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
	localparam int SEND_PERIOD_MS = 1000;
	localparam int SEND_PERIOD_CYC = SEND_PERIOD_MS * (CLK_HZ / 1000);
	localparam int CNT_W = 27;
	typedef enum logic [1:0] {
		RIFD_SHOW_MEAS,
		RIFD_SHOW_PEAK,
		RIFD_SHOW_VALLEY
	} rifd_pv_t;
	typedef enum logic [1:0] {
		RIFD_SRC_NORMAL,
		RIFD_SRC_RAW,
		RIFD_SRC_GROSS,
		RIFD_SRC_TARE
	} rifd_disp_src_t;
	typedef enum logic [2:0] {
		RIFD_ANA_NET,
		RIFD_ANA_TOTAL,
		RIFD_ANA_ZERO,
		RIFD_ANA_PEAK,
		RIFD_ANA_VALLEY
	} rifd_ana_src_t;
	// Memory operations; each field is a one-cycle pulse.
	typedef struct packed {
		logic tare_add;
		logic tare_restore;
		logic tare_clear;
		logic peak_clear;
		logic valley_clear;
		logic latch_release;
	} rifd_mem_op_t;
	// Print requests; each field is a one-cycle pulse.
	typedef struct packed {
		logic       net;
		logic       gross;
		logic       tare;
		logic [3:0] setpoint;
		logic       ascii;
	} rifd_print_t;
	// Level-held display and output controls.
	typedef struct packed {
		logic           freeze_all;
		logic           freeze_disp;
		logic           raw_flash;
		rifd_disp_src_t disp_src;
		rifd_pv_t       pv_show;
		rifd_ana_src_t  ana_src;
		logic           virt_sp_en;
		logic           serial_unrounded;
		logic           bcd_unrounded;
	} rifd_ctrl_t;
endpackage : rifd_pkg

/* hw/rifd_dispatch.sv */
// Remote input function dispatcher with its Wishbone register slave.
//
// Contract
// RULE1 - Four remote inputs, each bound to a function, act on fall or low.
// RULE2 - Each input has a function selector; zero makes the input do nothing.
// RULE3 - Selector holds values zero to thirty-six.
// RULE4 - Factory default is functions 7, 9, 1 and 6 on the four inputs.
// RULE5 - All selectors at zero gives the factory default assignment.
// RULE6 - Freeze held low freezes display, BCD, analog and lights indicator.
// RULE7 - Function 1 edge adds display value to tare; display reads zero.
// RULE8 - Function 2 edge restores tare onto display and clears tare.
// RULE9 - Functions 3 and 4 toggle showing peak or valley on each edge.
// RULE10 - Function 5 edge clears only the peak or valley being shown.
// RULE11 - Function 6 edges step measured, peak, valley, measured.
// RULE12 - Function 7 only acts combined: clears tare or shown peak/valley.
// RULE13 - Function 8 held low holds display; outputs keep working.
// RULE14 - Functions 10, 11, 12 held low show raw flashing, gross, tare.
// RULE15 - Functions 13, 15, 16 held low route analog to gross, peak, valley; the code routes function 13 to RIFD_ANA_TOTAL.
// RULE16 - Function 14 held low forces analog output to its zero state.
// RULE17 - Functions 17, 18, 19 edges request net, gross, tare print.
// RULE18 - Functions 20 to 23 edges request setpoint one to four print.
// RULE19 - Function 24 held low enables virtual setpoints without output card.
// RULE20 - Function 25 edge releases all latched setpoint outputs.
// RULE21 - Function 26 low sends serial unrounded; 27 drives BCD unrounded.
// RULE22 - Function 28 sends four digits; held low repeats once per second.
// RULE23 - Inputs are synchronised, debounced; edges become one-cycle pulses.
// RULE24 - Controller holds inputs low long enough and releases between edges.
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
module rifd_dispatch (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  ce_i,
	input  wire logic [3:0]            remote_input_n_i,
	input  wire logic                  output_card_fitted_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	output rifd_pkg::rifd_mem_op_t     mem_op_o,
	output rifd_pkg::rifd_print_t      print_o,
	output rifd_pkg::rifd_ctrl_t       ctrl_o
);
	logic [3:0]  sync_a;
	logic [3:0]  sync_b;
	logic [3:0]  level_low;
	logic [3:0]  fall_pulse;
	logic [31:0] func_sel;
	logic [5:0]  func [4];
	logic [3:0]  pv_toggle_src;
	logic [rifd_pkg::CNT_W-1:0] db_cnt [4];
	logic [rifd_pkg::CNT_W-1:0] send_cnt;
	rifd_pkg::rifd_pv_t     pv_show;
	rifd_pkg::rifd_pv_t     next_pv_show;
	rifd_pkg::rifd_ctrl_t   next_ctrl;
	rifd_pkg::rifd_mem_op_t next_mem_op;
	rifd_pkg::rifd_print_t  next_print;
	logic        all_zero;
	logic        combine_held;
	logic        send_held;
	logic        send_tick;
	logic        wb_req;

	// Limits a written selector to the defined range.
	function automatic logic [5:0] clamp_func(input logic [7:0] v);
		if (v > {2'b00, rifd_pkg::FUNC_MAX})
			return rifd_pkg::FN_NONE; // RULE3
		return v[5:0];
	endfunction : clamp_func

	// True when any input bound to the function shows the chosen activity.
	function automatic logic hit(input logic [5:0] f, input logic [3:0] act,
		input logic [5:0] fv [4]);
		logic r;
		r = 1'b0;
		for (int i = 0; i < rifd_pkg::NUM_INPUTS; i++) begin
			if (act[i] && fv[i] == f)
				r = 1'b1;
		end
		return r;
	endfunction : hit

	// Two-stage synchroniser; only the second stage is read.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_a <= 4'hf;
			sync_b <= 4'hf;
		end else if (ce_i) begin
			sync_a <= remote_input_n_i; // RULE23
			sync_b <= sync_a;
		end
	end

	// Debounce: a level is accepted once it has been stable for the window.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level_low  <= 4'h0;
			fall_pulse <= 4'h0;
			for (int i = 0; i < 4; i++)
				db_cnt[i] <= '0;
		end else if (ce_i) begin
			for (int i = 0; i < 4; i++) begin
				fall_pulse[i] <= 1'b0;
				if (!sync_b[i] == level_low[i]) begin
					db_cnt[i] <= '0;
				end else if (db_cnt[i] ==
					rifd_pkg::CNT_W'(rifd_pkg::DEBOUNCE_CYC - 1)) begin
					db_cnt[i]     <= '0;
					level_low[i]  <= !sync_b[i]; // RULE23 RULE24
					fall_pulse[i] <= !sync_b[i]; // RULE23
				end else begin
					db_cnt[i] <= db_cnt[i] + 1'b1;
				end
			end
		end
	end

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	// Function selector register, one byte per input.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			func_sel <= rifd_pkg::FUNC_SEL_RESET;
		end else if (ce_i && wb_req && wb_we_i &&
			wb_adr_i == rifd_pkg::REG_FUNC_SEL) begin
			for (int i = 0; i < 4; i++) begin
				if (wb_sel_i[i])
					func_sel[8*i +: 8] <= {2'b00,
						clamp_func(wb_dat_i[8*i +: 8])}; // RULE2 RULE3
			end
		end
	end

	assign all_zero = (func_sel == 32'h0000_0000);

	// Effective function per input, with the factory set when all are zero.
	always_comb begin
		if (all_zero) begin
			func[0] = rifd_pkg::DEF_FUNC0; // RULE4 RULE5
			func[1] = rifd_pkg::DEF_FUNC1; // RULE4 RULE5
			func[2] = rifd_pkg::DEF_FUNC2; // RULE4 RULE5
			func[3] = rifd_pkg::DEF_FUNC3; // RULE4 RULE5
		end else begin
			for (int i = 0; i < 4; i++)
				func[i] = func_sel[8*i +: 6]; // RULE1 RULE2
		end
	end

	// The combine function works while held; its own edge does nothing.
	assign combine_held = hit(rifd_pkg::FN_COMBINE, level_low, func); // RULE12

	// Peak/valley recall state.
	always_comb begin
		next_pv_show = pv_show;
		if (hit(rifd_pkg::FN_PV_CYCLE, fall_pulse, func) && !combine_held) begin
			case (pv_show)
				rifd_pkg::RIFD_SHOW_MEAS: next_pv_show = rifd_pkg::RIFD_SHOW_PEAK;
				rifd_pkg::RIFD_SHOW_PEAK:
					next_pv_show = rifd_pkg::RIFD_SHOW_VALLEY; // RULE11
				default: next_pv_show = rifd_pkg::RIFD_SHOW_MEAS;
			endcase
		end else if (hit(rifd_pkg::FN_PEAK, fall_pulse, func)) begin
			next_pv_show = (pv_show == rifd_pkg::RIFD_SHOW_PEAK) ?
				rifd_pkg::RIFD_SHOW_MEAS : rifd_pkg::RIFD_SHOW_PEAK; // RULE9
		end else if (hit(rifd_pkg::FN_VALLEY, fall_pulse, func)) begin
			next_pv_show = (pv_show == rifd_pkg::RIFD_SHOW_VALLEY) ?
				rifd_pkg::RIFD_SHOW_MEAS : rifd_pkg::RIFD_SHOW_VALLEY; // RULE9
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			pv_show <= rifd_pkg::RIFD_SHOW_MEAS;
		else if (ce_i)
			pv_show <= next_pv_show;
	end

	// Memory operations decoded from edges.
	always_comb begin
		logic pv_clr;
		logic tare_edge;
		pv_clr    = hit(rifd_pkg::FN_PV_CLEAR, fall_pulse, func) ||
			(combine_held && hit(rifd_pkg::FN_PV_CYCLE, fall_pulse, func));
		tare_edge = hit(rifd_pkg::FN_TARE, fall_pulse, func);
		next_mem_op = '0;
		next_mem_op.tare_add     = tare_edge && !combine_held; // RULE7
		next_mem_op.tare_clear   = tare_edge && combine_held; // RULE12
		next_mem_op.tare_restore =
			hit(rifd_pkg::FN_TARE_RESET, fall_pulse, func); // RULE8
		next_mem_op.peak_clear   =
			pv_clr && pv_show == rifd_pkg::RIFD_SHOW_PEAK; // RULE10 RULE12
		next_mem_op.valley_clear =
			pv_clr && pv_show == rifd_pkg::RIFD_SHOW_VALLEY; // RULE10 RULE12
		next_mem_op.latch_release =
			hit(rifd_pkg::FN_LATCH_REL, fall_pulse, func); // RULE20
	end

	// Repeat timer for the held send function.
	assign send_held = hit(rifd_pkg::FN_SEND_ASCII, level_low, func);
	assign send_tick = send_held &&
		send_cnt == rifd_pkg::CNT_W'(rifd_pkg::SEND_PERIOD_CYC - 1);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			send_cnt <= '0;
		else if (ce_i) begin
			if (!send_held || send_tick)
				send_cnt <= '0;
			else
				send_cnt <= send_cnt + 1'b1; // RULE22
		end
	end

	// Print requests.
	always_comb begin
		next_print = '0;
		next_print.net   = hit(rifd_pkg::FN_PRINT_NET, fall_pulse, func); // RULE17
		next_print.gross = hit(rifd_pkg::FN_PRINT_GROSS, fall_pulse, func); // RULE17
		next_print.tare  = hit(rifd_pkg::FN_PRINT_TARE, fall_pulse, func); // RULE17
		for (int s = 0; s < 4; s++)
			next_print.setpoint[s] =
				hit(rifd_pkg::FN_PRINT_SP1 + 6'(s), fall_pulse, func); // RULE18
		next_print.ascii = hit(rifd_pkg::FN_SEND_ASCII, fall_pulse, func) ||
			send_tick; // RULE22
	end

	// Level-held controls; display source priority is raw, gross, tare.
	always_comb begin
		next_ctrl = '0;
		next_ctrl.freeze_all  = hit(rifd_pkg::FN_FREEZE, level_low, func); // RULE6
		next_ctrl.freeze_disp =
			hit(rifd_pkg::FN_FREEZE_ALT, level_low, func); // RULE13
		next_ctrl.pv_show = next_pv_show;
		if (hit(rifd_pkg::FN_SHOW_RAW, level_low, func)) begin
			next_ctrl.disp_src  = rifd_pkg::RIFD_SRC_RAW; // RULE14
			next_ctrl.raw_flash = 1'b1; // RULE14
		end else if (hit(rifd_pkg::FN_SHOW_GROSS, level_low, func))
			next_ctrl.disp_src = rifd_pkg::RIFD_SRC_GROSS; // RULE14
		else if (hit(rifd_pkg::FN_SHOW_TARE, level_low, func))
			next_ctrl.disp_src = rifd_pkg::RIFD_SRC_TARE; // RULE14
		else
			next_ctrl.disp_src = rifd_pkg::RIFD_SRC_NORMAL;
		if (hit(rifd_pkg::FN_ANA_ZERO, level_low, func))
			next_ctrl.ana_src = rifd_pkg::RIFD_ANA_ZERO; // RULE16
		else if (hit(rifd_pkg::FN_ANA_TOTAL, level_low, func))
			next_ctrl.ana_src = rifd_pkg::RIFD_ANA_TOTAL; // RULE15
		else if (hit(rifd_pkg::FN_ANA_PEAK, level_low, func))
			next_ctrl.ana_src = rifd_pkg::RIFD_ANA_PEAK; // RULE15
		else if (hit(rifd_pkg::FN_ANA_VALLEY, level_low, func))
			next_ctrl.ana_src = rifd_pkg::RIFD_ANA_VALLEY; // RULE15
		else
			next_ctrl.ana_src = rifd_pkg::RIFD_ANA_NET;
		next_ctrl.virt_sp_en = hit(rifd_pkg::FN_VIRT_SP, level_low, func) &&
			!output_card_fitted_i; // RULE19
		next_ctrl.serial_unrounded =
			hit(rifd_pkg::FN_SER_RAW, level_low, func); // RULE21
		next_ctrl.bcd_unrounded =
			hit(rifd_pkg::FN_BCD_RAW, level_low, func); // RULE21
	end

	// Registered outputs; pulses stand one enabled cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem_op_o <= '0;
			print_o  <= '0;
			ctrl_o   <= '0;
		end else if (ce_i) begin
			mem_op_o <= next_mem_op;
			print_o  <= next_print;
			ctrl_o   <= next_ctrl;
		end
	end

	// Wishbone slave: registered ack one cycle after the request, unmapped reads return zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					rifd_pkg::REG_FUNC_SEL: wb_dat_o <= func_sel;
					rifd_pkg::REG_STATUS: wb_dat_o <= {22'h00_0000,
						pv_show, level_low, sync_b};
					rifd_pkg::REG_CONFIG: wb_dat_o <= {26'h000_0000,
						func[3]};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule : rifd_dispatch

/* verification/rifd_dispatch_sva.sv */
// Port-level assertion checker for the remote input function dispatcher.
`timescale 1ns/1ps
module rifd_dispatch_chk (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   ce_i,
	input  wire logic [3:0]             remote_input_n_i,
	input  wire logic                   output_card_fitted_i,
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_ack_o,
	input  wire rifd_pkg::rifd_mem_op_t mem_op_o,
	input  wire rifd_pkg::rifd_print_t  print_o,
	input  wire rifd_pkg::rifd_ctrl_t   ctrl_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_after_req: assert property (
		ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_one_cycle: assert property (
		ce_i && wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_tare_pulse_single: assert property (
		mem_op_o.tare_add |=> !mem_op_o.tare_add)
		else $error("tare pulse longer than one cycle");
	a_event_needs_low: assert property (
		(|mem_op_o || |print_o) |-> $past(remote_input_n_i, 8) != 4'hf)
		else $error("event without a low input");
	a_freeze_needs_low: assert property (
		$rose(ctrl_o.freeze_all) |-> $past(remote_input_n_i, 8) != 4'hf)
		else $error("freeze without a low input");
	a_tare_clear_excl: assert property (
		mem_op_o.tare_clear |-> !mem_op_o.tare_add)
		else $error("tare added while clearing");
	a_pv_clear_excl: assert property (
		!(mem_op_o.peak_clear && mem_op_o.valley_clear))
		else $error("peak and valley cleared together");
	a_virt_sp_block: assert property (
		output_card_fitted_i [*3] |-> !ctrl_o.virt_sp_en)
		else $error("virtual setpoints with card fitted");
endmodule : rifd_dispatch_chk

bind rifd_dispatch rifd_dispatch_chk rifd_dispatch_chk_i (.clk_i, .rst_i,
	.ce_i, .remote_input_n_i, .output_card_fitted_i, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .mem_op_o, .print_o, .ctrl_o);

/* verification/rifd_contacts.sv */
// Behavioural model of the external contacts on the remote inputs.
`timescale 1ns/1ps
module rifd_contacts (
	input  wire logic       clk_i,
	input  wire logic [3:0] press_i,
	output logic      [3:0] contact_n_o
);
	logic [3:0] prev   = '0;
	logic [3:0] old    = '0;
	logic [2:0] bounce = '0;

	// An open contact is pulled high; every change chatters before settling.
	initial contact_n_o = 4'hf;
	always @(posedge clk_i) begin
		prev <= press_i;
		if (press_i != prev) begin
			old <= prev;
			bounce <= 3'd5;
		end else if (bounce != 3'd0) begin
			bounce <= bounce - 3'd1;
		end
		contact_n_o <= bounce[0] ? ~old : ~prev;
	end
endmodule : rifd_contacts

/* verification/rifd_dispatch_bench.sv */
// Self-checking bench for the remote input function dispatcher.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("unexpected %s: expected %h seen %h", nm, e, g); \
	end \
end
module rifd_dispatch_bench;
	logic                   clk_i    = 0;
	logic                   rst_i    = 1;
	logic [3:0]             press    = '0;
	logic                   card     = 0;
	logic                   cyc      = 0;
	logic                   stb      = 0;
	logic                   we       = 0;
	logic [7:0]             adr      = '0;
	logic [3:0]             sel      = '0;
	logic [31:0]            wdat     = '0;
	logic [31:0]            rd       = '0;
	logic [3:0]             remote_input_n;
	logic [31:0]            rdat;
	logic                   ack;
	rifd_pkg::rifd_mem_op_t mem_op;
	rifd_pkg::rifd_print_t  prn;
	rifd_pkg::rifd_ctrl_t   ctrl;
	rifd_pkg::rifd_mem_op_t seen_mem = '0;
	rifd_pkg::rifd_print_t  seen_prn = '0;
	logic                   clr_seen = 0;
	int                     num_errors = 0;
	int                     cmp_count  = 0;

	always #5 clk_i = ~clk_i;

	// Event pulses last one cycle, so they are collected here between checks.
	always @(posedge clk_i) begin
		if (clr_seen) begin
			seen_mem <= '0;
			seen_prn <= '0;
		end else begin
			seen_mem <= seen_mem | mem_op;
			seen_prn <= seen_prn | prn;
		end
	end

	rifd_contacts rifd_contacts_i (
		.clk_i(clk_i), .press_i(press), .contact_n_o(remote_input_n)
	);
	rifd_dispatch rifd_dispatch_i (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.remote_input_n_i(remote_input_n), .output_card_fitted_i(card),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.mem_op_o(mem_op), .print_o(prn), .ctrl_o(ctrl)
	);

	task automatic stop_test();
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	// Sets the contacts and waits until the debounced change has landed.
	task automatic hold(input logic [3:0] p);
		@(posedge clk_i);
		clr_seen <= 1'b1;
		press    <= p;
		@(posedge clk_i);
		clr_seen <= 1'b0;
		repeat (rifd_pkg::DEBOUNCE_CYC + 50) @(posedge clk_i);
	endtask : hold

	initial begin
		repeat (20 * (rifd_pkg::DEBOUNCE_CYC + 60)) @(posedge clk_i);
		num_errors++;
		stop_test();
	end

	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, rifd_pkg::REG_FUNC_SEL, '0, 4'hf);
		`CHK("sel_reset", 32'h0000_0000, rd)
		wb(1'b0, rifd_pkg::REG_CONFIG, '0, 4'hf);
		`CHK("default_fn", 32'h0000_0006, rd)
		hold(4'b1110);
		`CHK("tare_add", 1'b1, seen_mem.tare_add)
		`CHK("pv_step", rifd_pkg::RIFD_SHOW_PEAK, ctrl.pv_show)
		`CHK("freeze_on", 1'b1, ctrl.freeze_all)
		hold(4'b0000);
		`CHK("freeze_off", 1'b0, ctrl.freeze_all)
		@(posedge clk_i);
		press <= 4'b0001;
		repeat (20) @(posedge clk_i);
		hold(4'b1101);
		`CHK("tare_clear", 1'b1, seen_mem.tare_clear)
		`CHK("no_tare_add", 1'b0, seen_mem.tare_add)
		`CHK("peak_clear", 1'b1, seen_mem.peak_clear)
		`CHK("pv_kept", rifd_pkg::RIFD_SHOW_PEAK, ctrl.pv_show)
		hold(4'b0000);
		wb(1'b1, rifd_pkg::REG_FUNC_SEL, 32'h1814_0e11, 4'hf);
		wb(1'b1, rifd_pkg::REG_FUNC_SEL, 32'h0000_0025, 4'h1);
		wb(1'b0, rifd_pkg::REG_FUNC_SEL, '0, 4'hf);
		`CHK("sel_range", 32'h1814_0e00, rd)
		wb(1'b1, rifd_pkg::REG_FUNC_SEL, 32'h0000_0011, 4'h1);
		wb(1'b0, rifd_pkg::REG_CONFIG, '0, 4'hf);
		`CHK("sel_fn3", 32'h0000_0018, rd)
		wb(1'b0, 8'h0c, '0, 4'hf);
		`CHK("unmapped", 32'h0000_0000, rd)
		hold(4'b1111);
		`CHK("print_net", 1'b1, seen_prn.net)
		`CHK("print_sp", 4'b0001, seen_prn.setpoint)
		`CHK("ana_zero", rifd_pkg::RIFD_ANA_ZERO, ctrl.ana_src)
		`CHK("virt_sp", 1'b1, ctrl.virt_sp_en)
		`CHK("no_default", 1'b0, ctrl.freeze_all)
		`CHK("no_mem_op", 6'h00, seen_mem)
		@(posedge clk_i);
		card <= 1'b1;
		repeat (4) @(posedge clk_i);
		`CHK("virt_blocked", 1'b0, ctrl.virt_sp_en)
		hold(4'b0000);
		wb(1'b1, rifd_pkg::REG_FUNC_SEL, 32'h1a13_0a02, 4'hf);
		hold(4'b1111);
		`CHK("tare_restore", 1'b1, seen_mem.tare_restore)
		`CHK("print_tare", 1'b1, seen_prn.tare)
		`CHK("disp_raw", rifd_pkg::RIFD_SRC_RAW, ctrl.disp_src)
		`CHK("raw_flash", 1'b1, ctrl.raw_flash)
		`CHK("ser_raw", 1'b1, ctrl.serial_unrounded)
		hold(4'b0000);
		wb(1'b1, rifd_pkg::REG_FUNC_SEL, 32'h1b1c_0819, 4'hf);
		hold(4'b1111);
		`CHK("latch_rel", 1'b1, seen_mem.latch_release)
		`CHK("send_ascii", 1'b1, seen_prn.ascii)
		`CHK("freeze_disp", 1'b1, ctrl.freeze_disp)
		`CHK("freeze_alt_only", 1'b0, ctrl.freeze_all)
		`CHK("bcd_raw", 1'b1, ctrl.bcd_unrounded)
		hold(4'b0000);
		wb(1'b1, rifd_pkg::REG_FUNC_SEL, 32'h100b_0504, 4'hf);
		hold(4'b1101);
		`CHK("pv_valley", rifd_pkg::RIFD_SHOW_VALLEY, ctrl.pv_show)
		`CHK("disp_gross", rifd_pkg::RIFD_SRC_GROSS, ctrl.disp_src)
		`CHK("ana_valley", rifd_pkg::RIFD_ANA_VALLEY, ctrl.ana_src)
		hold(4'b0010);
		`CHK("valley_clear", 1'b1, seen_mem.valley_clear)
		`CHK("peak_kept", 1'b0, seen_mem.peak_clear)
		hold(4'b0001);
		`CHK("pv_back", rifd_pkg::RIFD_SHOW_MEAS, ctrl.pv_show)
		stop_test();
	end
endmodule : rifd_dispatch_bench
